// File: pfc_bus_cycle.sv
`timescale 1ns/1ns
// One strobed bus cycle on the flash pins, write or read
module pfc_bus_cycle
    import pfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic is_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] dq_in_sync,
    output pfc_pkg::pfc_pins_t pins,
    output logic [7:0] rdata,
    output logic done
);
    import pfc_pkg::*;
    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD} pfc_cyc_t;
    pfc_cyc_t st_reg;
    logic [3:0] cnt_reg;
    logic wr_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= C_IDLE;
            cnt_reg <= 4'h0;
            wr_reg <= 1'b0;
            pins <= '{addr: '0, dq_out: 8'h00, dq_oe: 1'b0,
                ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            rdata <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st_reg)
                C_IDLE: begin
                    if (start) begin
                        // Address stable before strobes fall
                        pins.addr <= addr;
                        pins.dq_out <= wdata;
                        pins.dq_oe <= is_write;
                        pins.ce_n <= 1'b0;
                        wr_reg <= is_write;
                        cnt_reg <= 4'(SETUP_CYC - 1);
                        st_reg <= C_SETUP;
                    end
                end
                C_SETUP: begin
                    if (cnt_reg == 4'h0) begin
                        pins.we_n <= !wr_reg;
                        // Never drive dq while reading
                        pins.oe_n <= wr_reg;
                        cnt_reg <= 4'(wr_reg ? PULSE_CYC - 1 : READ_CYC);
                        st_reg <= C_PULSE;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                C_PULSE: begin
                    if (cnt_reg == 4'h0) begin
                        // Data held across the rising strobe
                        pins.we_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        rdata <= dq_in_sync;
                        cnt_reg <= 4'(HOLD_CYC - 1);
                        st_reg <= C_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                C_HOLD: begin
                    if (cnt_reg == 4'h0) begin
                        // Deselect between cycles
                        pins.ce_n <= 1'b1;
                        pins.dq_oe <= 1'b0;
                        done <= 1'b1;
                        st_reg <= C_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: st_reg <= C_IDLE;
            endcase
        end
    end
endmodule

// File: pfc_flash_model.sv
`timescale 1ns/1ns
// Host pins are registered, so the clock only paces busy time and samples the kept bus value
module pfc_flash_model
    import pfc_pkg::*;
#(
    parameter int PROT_HI = 32'h3fff
)
(
    input wire logic clk,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] host_dq,
    input wire logic host_oe,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic [7:0] dq
);
    logic [7:0] mem [int];
    logic [7:0] last_reg = 8'h00;
    logic [7:0] rd_reg = 8'h00;
    logic bit7 = 1'b0;
    logic tog = 1'b0;
    int lat_a = 0;
    int step = 0;
    int busy = 0;
    int prog_cyc = 150;
    int erase_cyc = 300;
    task automatic decode(input logic [7:0] d);
        logic u1;
        logic u2;
        u1 = lat_a == UNLOCK_ADDR1;
        u2 = lat_a == UNLOCK_ADDR2;
        case (step)
            0, 4: step = (u1 && d == UNLOCK_DATA1) ? step + 1 : 0;
            1, 5: step = (u2 && d == UNLOCK_DATA2) ? step + 1 : 0;
            2: step = !u1 ? 0 : d == CMD_PROGRAM ? 3 :
                d == CMD_ERASE_SETUP ? 4 : 0;
            3: begin
                step = 0;
                if (lat_a > PROT_HI) begin
                    mem[lat_a] = d;
                    bit7 = ~d[7];
                    busy = prog_cyc;
                end
            end
            default: begin
                step = 0;
                bit7 = 1'b0;
                if (d == CMD_CHIP_ERASE && u1) begin
                    foreach (mem[k])
                        if (k > PROT_HI) mem[k] = ERASED_BYTE;
                    busy = erase_cyc;
                end
                if (d == CMD_SECTOR_ERASE
                    && lat_a > PROT_HI) begin
                    foreach (mem[k])
                        if (k >> SECTOR_LSB == lat_a >> SECTOR_LSB)
                            mem[k] = ERASED_BYTE;
                    busy = erase_cyc;
                end
            end
        endcase
    endtask
    always @(negedge we_n) if (!ce_n) lat_a = int'(addr);
    always @(posedge we_n) begin
        if (!ce_n && busy == 0)
            decode(host_dq);
    end
    always @(posedge clk) if (busy > 0) busy = busy - 1;
    always @(negedge oe_n) begin
        if (!ce_n && busy > 0) begin
            tog = ~tog;
            rd_reg = {bit7, tog, 6'h00};
        end else if (!ce_n)
            rd_reg = mem.exists(int'(addr)) ? mem[int'(addr)]
                : ERASED_BYTE;
    end
    always @(posedge clk) if (host_oe || !ce_n && !oe_n) last_reg <= dq;
    // Released bus shows the inverse of the kept value
    assign dq = host_oe ? host_dq
        : (!ce_n && !oe_n) ? rd_reg : ~last_reg;
endmodule

// File: pfc_host.sv
`timescale 1ns/1ns
// Host side sequencer: turns one program or erase request into the flash command sequence,
// then polls status until the internal operation ends, or until a program times out and raises FAIL.
module pfc_host
    import pfc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input pfc_pkg::pfc_req_t REQ,
    output logic REQ_READY,
    output logic DONE,
    output logic FAIL,
    output logic [7:0] RDATA,
    output logic [pfc_pkg::ADDR_W-1:0] FLASH_ADDR,
    input wire logic [7:0] FLASH_DQ_IN,
    output logic [7:0] FLASH_DQ_OUT,
    output logic FLASH_DQ_OE,
    output logic FLASH_CE_N,
    output logic FLASH_OE_N,
    output logic FLASH_WE_N
);
    import pfc_pkg::*;
    typedef enum logic [2:0] {S_IDLE, S_WRITE, S_READ, S_POLL1, S_POLL2,
        S_CHECK, S_FINISH} pfc_state_t;

    pfc_state_t st_reg;
    pfc_req_t req_reg;
    logic [2:0] step_reg;
    logic [7:0] meta_reg;
    logic [7:0] dq_sync_reg;
    logic [7:0] first_reg;
    logic [1:0] recheck_reg;
    logic [15:0] time_reg;
    logic cyc_start;
    logic cyc_write;
    logic [ADDR_W-1:0] cyc_addr;
    logic [7:0] cyc_data;
    logic [7:0] cyc_rdata;
    logic cyc_done;
    logic u_busy;
    logic [2:0] seq_len;
    logic status_done;
    logic [7:0] expect_byte;
    pfc_pins_t pins;

    // Pins from the flash are asynchronous to CLK
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            meta_reg <= 8'h00;
            dq_sync_reg <= 8'h00;
        end else begin
            meta_reg <= FLASH_DQ_IN;
            dq_sync_reg <= meta_reg;
        end
    end

    pfc_bus_cycle u_cycle (
        .clk(CLK),
        .rst_n(RST_N),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .dq_in_sync(dq_sync_reg),
        .pins(pins),
        .rdata(cyc_rdata),
        .done(cyc_done)
    );

    assign FLASH_ADDR = pins.addr;
    assign FLASH_DQ_OUT = pins.dq_out;
    assign FLASH_DQ_OE = pins.dq_oe;
    assign FLASH_CE_N = pins.ce_n;
    assign FLASH_OE_N = pins.oe_n;
    assign FLASH_WE_N = pins.we_n;
    assign REQ_READY = (st_reg == S_IDLE);

    always_comb begin
        case (req_reg.op)
            OP_PROGRAM: seq_len = 3'd4;
            OP_SECTOR_ERASE: seq_len = 3'd6;
            OP_CHIP_ERASE: seq_len = 3'd6;
            default: seq_len = 3'd0;
        endcase
    end

    // Unlock pattern, then command
    always_comb begin
        cyc_addr = UNLOCK_ADDR1;
        cyc_data = UNLOCK_DATA1;
        case (step_reg)
            3'd0: begin
                cyc_addr = UNLOCK_ADDR1;
                cyc_data = UNLOCK_DATA1;
            end
            3'd1: begin
                cyc_addr = UNLOCK_ADDR2;
                cyc_data = UNLOCK_DATA2;
            end
            3'd2: begin
                cyc_addr = UNLOCK_ADDR1;
                cyc_data = (req_reg.op == OP_PROGRAM) ? CMD_PROGRAM
                    : CMD_ERASE_SETUP;
            end
            3'd3: begin
                cyc_addr = (req_reg.op == OP_PROGRAM) ? req_reg.addr
                    : UNLOCK_ADDR1;
                cyc_data = (req_reg.op == OP_PROGRAM) ? req_reg.data
                    : UNLOCK_DATA1;
            end
            3'd4: begin
                cyc_addr = UNLOCK_ADDR2;
                cyc_data = UNLOCK_DATA2;
            end
            default: begin
                if (req_reg.op == OP_SECTOR_ERASE) begin
                    // Only the sector bits matter
                    cyc_addr = {req_reg.addr[ADDR_W-1:SECTOR_LSB],
                        {SECTOR_LSB{1'b0}}};
                    cyc_data = CMD_SECTOR_ERASE;
                end else begin
                    cyc_addr = UNLOCK_ADDR1;
                    cyc_data = CMD_CHIP_ERASE;
                end
            end
        endcase
        if (st_reg != S_WRITE) begin
            cyc_addr = req_reg.addr;
        end
    end

    assign cyc_write = (st_reg == S_WRITE);
    assign cyc_start = (st_reg == S_WRITE || st_reg == S_READ
        || st_reg == S_POLL1 || st_reg == S_POLL2 || st_reg == S_CHECK)
        && !cyc_done && (pins.ce_n && pins.we_n && pins.oe_n)
        && !u_busy;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            u_busy <= 1'b0;
        end else if (cyc_start) begin
            u_busy <= 1'b1;
        end else if (cyc_done) begin
            u_busy <= 1'b0;
        end
    end

    assign expect_byte = (req_reg.op == OP_PROGRAM) ? req_reg.data
        : ERASED_BYTE;
    // Toggle stopped and data line seven matching the expected byte means done
    assign status_done = (first_reg[POLL_TOGGLE_BIT]
        == cyc_rdata[POLL_TOGGLE_BIT])
        && (cyc_rdata[POLL_DATA_BIT] == expect_byte[POLL_DATA_BIT]);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_reg <= S_IDLE;
            req_reg <= '0;
            step_reg <= 3'd0;
            first_reg <= 8'h00;
            recheck_reg <= 2'd0;
            time_reg <= 16'h0000;
            DONE <= 1'b0;
            FAIL <= 1'b0;
            RDATA <= 8'h00;
        end else begin
            DONE <= 1'b0;
            if (st_reg != S_IDLE && time_reg != 16'hffff) begin
                time_reg <= time_reg + 16'h1;
            end
            case (st_reg)
                S_IDLE: begin
                    if (REQ_VALID) begin
                        req_reg <= REQ;
                        step_reg <= 3'd0;
                        time_reg <= 16'h0000;
                        FAIL <= 1'b0;
                        st_reg <= (REQ.op == OP_READ) ? S_READ : S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (cyc_done) begin
                        if (step_reg == seq_len - 3'd1) begin
                            // Status valid only after the launching write
                            time_reg <= 16'h0000;
                            st_reg <= S_POLL1;
                        end else begin
                            step_reg <= step_reg + 3'd1;
                        end
                    end
                end
                S_READ: begin
                    if (cyc_done) begin
                        RDATA <= cyc_rdata;
                        st_reg <= S_FINISH;
                    end
                end
                S_POLL1: begin
                    if (cyc_done) begin
                        first_reg <= cyc_rdata;
                        st_reg <= S_POLL2;
                    end
                end
                S_POLL2: begin
                    if (cyc_done) begin
                        if (status_done) begin
                            recheck_reg <= 2'(RECHECK_READS);
                            first_reg <= cyc_rdata;
                            st_reg <= S_CHECK;
                        end else if (req_reg.op == OP_PROGRAM
                            && time_reg >= 16'(PROG_TIMEOUT_CYC)) begin
                            // Program overran its bound
                            FAIL <= 1'b1;
                            st_reg <= S_FINISH;
                        end else begin
                            first_reg <= cyc_rdata;
                        end
                    end
                end
                S_CHECK: begin
                    // Two confirming reads guard a race with completion
                    if (cyc_done) begin
                        if (!status_done) begin
                            first_reg <= cyc_rdata;
                            st_reg <= S_POLL2;
                        end else if (recheck_reg == 2'd1) begin
                            RDATA <= cyc_rdata;
                            st_reg <= S_FINISH;
                        end else begin
                            recheck_reg <= recheck_reg - 2'd1;
                            first_reg <= cyc_rdata;
                        end
                    end
                end
                S_FINISH: begin
                    DONE <= 1'b1;
                    st_reg <= S_IDLE;
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// File: pfc_host_chk.sv
`timescale 1ns/1ns
module pfc_host_chk
    import pfc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input pfc_pkg::pfc_req_t REQ,
    input wire logic REQ_READY,
    input wire logic DONE,
    input wire logic FAIL,
    input wire logic [pfc_pkg::ADDR_W-1:0] FLASH_ADDR,
    input wire logic [7:0] FLASH_DQ_OUT,
    input wire logic FLASH_DQ_OE,
    input wire logic FLASH_CE_N,
    input wire logic FLASH_OE_N,
    input wire logic FLASH_WE_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    int cyc_reg;
    sequence s_acc(pfc_op_t o);
        REQ_VALID && REQ_READY && REQ.op == o;
    endsequence
    sequence s_unlock1;
        $fell(FLASH_WE_N) && FLASH_ADDR == UNLOCK_ADDR1
            && FLASH_DQ_OUT == UNLOCK_DATA1;
    endsequence
    sequence s_wr_pulse;
        (!FLASH_WE_N)[*3] ##1 FLASH_WE_N;
    endsequence
    // Saturates so a long erase cannot wrap it
    always_ff @(posedge CLK) begin
        if (!RST_N || (REQ_VALID && REQ_READY))
            cyc_reg <= 0;
        else if (cyc_reg < 2000)
            cyc_reg <= cyc_reg + 1;
    end
    a_we_under_ce: assert property (!FLASH_WE_N |-> !FLASH_CE_N)
        else $error("write while deselected");
    a_wr_pulse_len: assert property ($fell(FLASH_WE_N) |-> s_wr_pulse)
        else $error("bad write pulse");
    a_addr_held: assert property (!FLASH_WE_N |-> $stable(FLASH_ADDR))
        else $error("address moved in pulse");
    a_data_at_rise: assert property ($rose(FLASH_WE_N) |->
        $stable(FLASH_DQ_OUT) && FLASH_DQ_OE && !FLASH_CE_N)
        else $error("data not held at rise");
    a_no_contention: assert property (!FLASH_OE_N |->
        !FLASH_DQ_OE && !FLASH_CE_N)
        else $error("host drives during read");
    a_idle_pins: assert property (REQ_READY |->
        FLASH_CE_N && FLASH_OE_N && FLASH_WE_N && !FLASH_DQ_OE)
        else $error("bus busy while ready");
    a_prog_unlock: assert property (s_acc(OP_PROGRAM) |->
        ##[1:8] s_unlock1)
        else $error("no unlock write");
    a_read_no_write: assert property (s_acc(OP_READ) |=>
        FLASH_WE_N throughout (##[1:40] DONE))
        else $error("read wrote or hung");
    a_fail_late: assert property ($rose(FAIL) |->
        cyc_reg >= PROG_TIMEOUT_CYC)
        else $error("fail flagged early");
endmodule
bind pfc_host pfc_host_chk chk_u (.CLK(CLK), .RST_N(RST_N),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY), .DONE(DONE),
    .FAIL(FAIL), .FLASH_ADDR(FLASH_ADDR), .FLASH_DQ_OUT(FLASH_DQ_OUT),
    .FLASH_DQ_OE(FLASH_DQ_OE), .FLASH_CE_N(FLASH_CE_N),
    .FLASH_OE_N(FLASH_OE_N), .FLASH_WE_N(FLASH_WE_N));

// File: pfc_pkg.sv
// How it works
// - Host writes by pulling write strobe low while chip select is low.
// - Program is two unlock writes, then A0h at 5555h, then address and data write.
// - Sector erase is six writes ending with 30h at sector address.
// - Chip erase is six writes ending with 10h at 5555h.
// - On done status, read twice more; done only if both valid.
package pfc_pkg;
    localparam int ADDR_W = 19;
    localparam int CLK_MHZ = 25;
    localparam int PROG_MAX_US = 20;
    localparam int PROG_TIMEOUT_CYC = PROG_MAX_US * CLK_MHZ;
    // Erase has no printed upper bound; polling ends on status only
    localparam int SETUP_CYC = 2;
    localparam int PULSE_CYC = 3;
    localparam int HOLD_CYC = 2;
    localparam int READ_CYC = 3;
    localparam logic [18:0] UNLOCK_ADDR1 = 19'h05555;
    localparam logic [18:0] UNLOCK_ADDR2 = 19'h02aaa;
    localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
    localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int SECTOR_LSB = 12;
    localparam int POLL_TOGGLE_BIT = 6;
    localparam int POLL_DATA_BIT = 7;
    localparam int RECHECK_READS = 2;

    typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_SECTOR_ERASE,
        OP_CHIP_ERASE} pfc_op_t;

    typedef struct packed {
        pfc_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } pfc_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } pfc_pins_t;
endpackage

// File: test_pfc_host.sv
`timescale 1ns/1ns
module test_pfc_host;
    import pfc_pkg::*;
    typedef struct {
        pfc_op_t op;
        logic [ADDR_W-1:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } pfc_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    pfc_req_t req = '0;
    logic req_ready, done, fail, dq_oe, ce_n, oe_n, we_n;
    logic [7:0] rdata, dq_out, dq_in;
    logic [ADDR_W-1:0] f_addr;
    int fail_count = 0;
    int cmp_count = 0;
    pfc_row_t rows[11];
    pfc_host dut_u (.CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid),
        .REQ(req), .REQ_READY(req_ready), .DONE(done), .FAIL(fail),
        .RDATA(rdata), .FLASH_ADDR(f_addr), .FLASH_DQ_IN(dq_in),
        .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe), .FLASH_CE_N(ce_n),
        .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n));
    pfc_flash_model flash_u (.clk(clk), .addr(f_addr), .host_dq(dq_out),
        .host_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq(dq_in));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic run(input pfc_op_t op, input logic [ADDR_W-1:0] a,
        input logic [7:0] d);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{op, a, d};
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 4000);
        if (n == 4000)
            fail_count++;
    endtask
    initial begin
        rows = '{
            '{OP_PROGRAM, 19'h13000, 8'h77, 8'h77},
            '{OP_PROGRAM, 19'h12345, 8'h5a, 8'h5a},
            '{OP_READ, 19'h12345, 8'h00, 8'h5a},
            '{OP_SECTOR_ERASE, 19'h12345, 8'h00, 8'hff},
            '{OP_READ, 19'h12345, 8'h00, 8'hff},
            '{OP_READ, 19'h13000, 8'h00, 8'h77},
            '{OP_PROGRAM, 19'h00100, 8'h9c, 8'hff},
            '{OP_SECTOR_ERASE, 19'h01234, 8'h00, 8'hb7},
            '{OP_CHIP_ERASE, 19'h00000, 8'h00, 8'hff},
            '{OP_READ, 19'h00010, 8'h00, 8'h42},
            '{OP_READ, 19'h13000, 8'h00, 8'hff}};
        flash_u.mem[32'h10] = 8'h42;
        flash_u.mem[32'h1234] = 8'hb7;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].a, rows[i].d);
            chk(rdata, rows[i].e);
            chk({7'h00, fail}, 8'h00);
        end
        // Part slower than allowed: only the flag may report it
        flash_u.prog_cyc = 600;
        run(OP_PROGRAM, 19'h20000, 8'h81);
        chk({7'h00, fail}, 8'h01);
        flash_u.prog_cyc = 300;
        repeat (300) @(posedge clk);
        run(OP_READ, 19'h20000, 8'h00);
        chk(rdata, 8'h81);
        chk({7'h00, fail}, 8'h00);
        // Host reset while the part is still programming
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{OP_PROGRAM, 19'h22000, 8'h3e};
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (300) if (oe_n !== 1'b0) @(posedge clk);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({2'h0, done, ce_n, oe_n, we_n, dq_oe, req_ready}, 8'h1d);
        rst_n <= 1'b1;
        run(OP_PROGRAM, 19'h21000, 8'hcc);
        chk(rdata, 8'hff);
        run(OP_READ, 19'h22000, 8'h00);
        chk(rdata, 8'h3e);
        test_done();
    end
    initial begin
        #(40 * 30000);
        fail_count++;
        test_done();
    end
endmodule
